// File: src/pbr_power_ctl.sv
// Power button forwarding, supply-on drive, front-panel debounce,
// power-ok generation, power-failure recovery and wake requests.
// Assumes nrst is the standby-rail reset and battery_rst_n the battery
// reset; pins are asynchronous and all but keyboard_button_status_n are synchronised here.
//
// The plain strobed port is this design's own decision.
`include "pbr_map.svh"

module pbr_power_ctl #(
    parameter int PULSE_CYC = `PBR_PULSE_CYC,
    parameter int SAMPLE_TICKS = `PBR_SAMPLE_TICKS,
    parameter int DEB_TICKS = `PBR_DEB_TICKS,
    parameter int DIV_CYC = `PBR_DIV_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic battery_rst_n,
    input wire logic sleep_state_in_n,
    input wire logic chassis_button_in_n,
    input wire logic keyboard_button_status_n,
    input wire logic supply_good_in,
    input wire logic front_panel_reset_in_n,
    input wire logic slow_clk_in,
    input wire logic main_rail_good_in,
    input wire logic standby_rail_good_in,
    input wire logic power_ok_input,
    input wire logic standby_above_min_in,
    input wire pbr_pkg::pbr_byte_t addr,
    input wire pbr_pkg::pbr_byte_t wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic button_request_out_n,
    output logic supply_on_out_n,
    output logic system_good_out,
    output logic wake_request_out_n,
    output pbr_pkg::pbr_byte_t rd_data
);
    import pbr_pkg::*;

    localparam int NPIN = 9;
    localparam int P_SLEEP = 0;
    localparam int P_CHAS = 1;
    localparam int P_SGOOD = 2;
    localparam int P_FPRST = 3;
    localparam int P_SLOW = 4;
    localparam int P_MAIN = 5;
    localparam int P_STBY = 6;
    localparam int P_POK = 7;
    localparam int P_ABOVE = 8;
    localparam logic [NPIN-1:0] PIN_IDLE = 9'h1FF;

    generate
        if (PULSE_CYC < 1 || PULSE_CYC >= 2 ** 24) begin : g_bad_pulse
            $error("pulse count out of range");
        end
        if (SAMPLE_TICKS < 1 || SAMPLE_TICKS >= 2 ** 15) begin : g_bad_smp
            $error("sample count out of range");
        end
        if (DEB_TICKS < 1 || DEB_TICKS >= 2 ** 10) begin : g_bad_deb
            $error("debounce count out of range");
        end
        if (DIV_CYC < 1 || DIV_CYC >= 2 ** 10) begin : g_bad_div
            $error("divider count out of range");
        end
    endgenerate

    // Pin synchronisers: a change counts once stages two and three agree
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic [NPIN-1:0] sync3_reg;
    logic [NPIN-1:0] pin_reg;

    assign pin_raw = {standby_above_min_in, power_ok_input,
                      standby_rail_good_in, main_rail_good_in, slow_clk_in,
                      front_panel_reset_in_n, supply_good_in,
                      chassis_button_in_n, sleep_state_in_n};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                sync1_reg[gi] <= pin_raw[gi];
                sync2_reg[gi] <= sync1_reg[gi];
                sync3_reg[gi] <= sync2_reg[gi];
            end
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    pin_reg[gi] <= PIN_IDLE[gi];
                end else if (sync2_reg[gi] == sync3_reg[gi]) begin
                    pin_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    // Battery-backed control state
    logic [1:0] policy_reg;
    logic pok_en_reg;
    logic mode2_reg;
    logic prev_reg;
    logic chas_en_reg;
    logic clk_sel_reg;
    logic [7:0] shift_reg;
    logic [7:0] hist_reg;
    logic [2:0] sel_reg;
    logic [2:0] wake_en_reg;
    logic fail_seen_reg;
    logic above_q_reg;

    // Standby-domain state
    pbr_rec_t rec_reg;
    pbr_rec_t rec_next;
    logic want_on_reg;
    logic [23:0] pulse_cnt_reg;
    logic slow_q_reg;
    logic [9:0] div_cnt_reg;
    logic int_tick_reg;
    logic [14:0] smp_cnt_reg;
    logic [9:0] deb_cnt_reg;
    logic deb_reg;
    logic chas_q_reg;
    logic kb_q_reg;
    logic [2:0] wake_sts_reg;
    logic button_reg;
    logic supply_reg;
    logic good_reg;
    logic wake_reg;
    pbr_byte_t rd_data_reg;

    logic ext_tick;
    logic sel_tick;
    logic want_on;
    logic fail_any;
    logic [2:0] wake_set;
    logic wr_rec;

    assign ext_tick = pin_reg[P_SLOW] && !slow_q_reg;
    // External slow clock is lost with it when main rail is down
    assign sel_tick = clk_sel_reg ? int_tick_reg : ext_tick; // [RULE_16]
    assign wr_rec = wr_en && addr == `PBR_OFS_RECOVERY;

    // Reset to the filtered pin's reset level so no false tick follows reset
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            slow_q_reg <= 1'b1;
        end else begin
            slow_q_reg <= pin_reg[P_SLOW];
        end
    end

    // Internal slow clock from the core clock [RULE_16]
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            div_cnt_reg <= 10'h000;
            int_tick_reg <= 1'b0;
        end else if (div_cnt_reg == 10'(DIV_CYC - 1)) begin
            div_cnt_reg <= 10'h000;
            int_tick_reg <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 10'h001;
            int_tick_reg <= 1'b0;
        end
    end

    // Software-visible battery registers [RULE_22] [RULE_18]
    always_ff @(posedge mclk) begin
        if (!battery_rst_n) begin
            policy_reg <= `PBR_RST_POLICY;
            pok_en_reg <= 1'b0;
            mode2_reg <= 1'b0;
            chas_en_reg <= `PBR_RST_CHAS_EN;
            clk_sel_reg <= 1'b0;
            sel_reg <= 3'h0;
            wake_en_reg <= `PBR_RST_WAKE_EN;
        end else if (wr_en) begin
            if (addr == `PBR_OFS_RECOVERY) begin
                policy_reg <= wr_data[`PBR_BIT_POLICY_LO +: 2];
                pok_en_reg <= wr_data[`PBR_BIT_POK_EN];
                mode2_reg <= wr_data[`PBR_BIT_MODE2];
                chas_en_reg <= wr_data[`PBR_BIT_CHAS_EN];
                clk_sel_reg <= wr_data[`PBR_BIT_CLK_SEL];
            end
            if (addr == `PBR_OFS_SELECT) begin
                sel_reg <= wr_data[2:0];
            end
            if (addr == `PBR_OFS_WAKE_EN) begin
                wake_en_reg <= wr_data[2:0];
            end
        end
    end

    // Previous-state latch on the first failing rail in mode 1, on standby drop in mode 2
    assign fail_any = !pin_reg[P_MAIN] || !pin_reg[P_STBY] ||
                      (pok_en_reg && !pin_reg[P_POK]);

    always_ff @(posedge mclk) begin
        if (!battery_rst_n) begin
            prev_reg <= 1'b0;
            fail_seen_reg <= 1'b0;
            above_q_reg <= 1'b0;
        end else begin
            above_q_reg <= pin_reg[P_ABOVE];
            fail_seen_reg <= fail_any;
            if (!mode2_reg && fail_any && !fail_seen_reg) begin
                prev_reg <= !supply_reg; // [RULE_07]
            end else if (mode2_reg && above_q_reg && !pin_reg[P_ABOVE]) begin
                prev_reg <= !supply_reg; // [RULE_12]
            end
        end
    end

    // History shift register and saved copy
    always_ff @(posedge mclk) begin
        if (!battery_rst_n) begin
            shift_reg <= 8'h00;
            hist_reg <= 8'h00; // [RULE_11]
        end else if (nrst) begin
            if (rec_reg == REC_DECIDE) begin
                hist_reg <= shift_reg; // [RULE_10]
            end
            if (rec_reg == REC_COPY) begin
                shift_reg <= 8'h00; // [RULE_10]
            end else if (rec_reg != REC_DECIDE && mode2_reg &&
                         pin_reg[P_ABOVE] && sel_tick &&
                         smp_cnt_reg == 15'(SAMPLE_TICKS - 1)) begin
                shift_reg <= {shift_reg[6:0], !supply_reg}; // [RULE_08]
            end
        end
    end

    // Half-second sampling timer on the selected slow clock
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            smp_cnt_reg <= 15'h0000;
        end else if (sel_tick) begin
            if (smp_cnt_reg == 15'(SAMPLE_TICKS - 1)) begin
                smp_cnt_reg <= 15'h0000;
            end else begin
                smp_cnt_reg <= smp_cnt_reg + 15'h0001;
            end
        end
    end

    // Recovery decision on standby return
    always_comb begin
        case (policy_reg)
            2'h1: want_on = 1'b1; // [RULE_05]
            2'h2: want_on = mode2_reg ? shift_reg[sel_reg] : prev_reg; // [RULE_09]
            default: want_on = 1'b0; // [RULE_05]
        endcase
    end

    always_comb begin
        rec_next = rec_reg;
        case (rec_reg)
            REC_DECIDE: rec_next = REC_COPY;
            REC_COPY: rec_next = want_on_reg ? REC_PULSE : REC_DONE; // [RULE_06]
            REC_PULSE: begin
                if (pulse_cnt_reg == 24'(PULSE_CYC - 1)) begin
                    rec_next = REC_DONE;
                end
            end
            REC_DONE: rec_next = REC_DONE;
            default: rec_next = REC_DONE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rec_reg <= REC_DECIDE;
            want_on_reg <= 1'b0;
        end else begin
            rec_reg <= rec_next;
            if (rec_reg == REC_DECIDE) begin
                want_on_reg <= want_on;
            end
        end
    end

    // Pulse is exactly 0.5 s, far below the 4 s override
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pulse_cnt_reg <= 24'h000000;
        end else if (rec_reg == REC_PULSE) begin
            pulse_cnt_reg <= pulse_cnt_reg + 24'h000001; // [RULE_04]
        end else begin
            pulse_cnt_reg <= 24'h000000;
        end
    end

    // Front-panel debounce on the external slow clock only
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            deb_cnt_reg <= 10'h000;
            deb_reg <= 1'b1;
        end else if (pin_reg[P_FPRST] == deb_reg) begin
            deb_cnt_reg <= 10'h000; // [RULE_23]
        end else if (ext_tick) begin
            if (deb_cnt_reg == 10'(DEB_TICKS - 1)) begin
                deb_cnt_reg <= 10'h000;
                deb_reg <= pin_reg[P_FPRST]; // [RULE_14]
            end else begin
                deb_cnt_reg <= deb_cnt_reg + 10'h001;
            end
        end
    end

    // Pin outputs
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            button_reg <= 1'b1;
            supply_reg <= 1'b1;
            good_reg <= 1'b0;
        end else begin
            button_reg <= !((chas_en_reg && !pin_reg[P_CHAS]) || // [RULE_02]
                             !keyboard_button_status_n || // [RULE_03]
                             rec_reg == REC_PULSE); // [RULE_04]
            supply_reg <= !pin_reg[P_SLEEP]; // [RULE_01]
            good_reg <= deb_reg && pin_reg[P_SGOOD]; // [RULE_15]
        end
    end

    // Wake events; a new event wins over a clear in the same cycle
    assign wake_set[`PBR_WAKE_CHASSIS] = chas_q_reg && !pin_reg[P_CHAS];
    assign wake_set[`PBR_WAKE_KEYBOARD] = kb_q_reg && !keyboard_button_status_n;
    assign wake_set[`PBR_WAKE_RETURN] = rec_reg == REC_COPY && want_on_reg;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            chas_q_reg <= 1'b1;
            kb_q_reg <= 1'b1;
            wake_sts_reg <= 3'h0;
            wake_reg <= 1'b1;
        end else begin
            chas_q_reg <= pin_reg[P_CHAS];
            kb_q_reg <= keyboard_button_status_n;
            if (wr_en && addr == `PBR_OFS_WAKE_STS) begin
                wake_sts_reg <= (wake_sts_reg & ~wr_data[2:0]) | wake_set;
            end else begin
                wake_sts_reg <= wake_sts_reg | wake_set; // [RULE_17] [RULE_19]
            end
            wake_reg <= !(|(wake_sts_reg & wake_en_reg)); // [RULE_17]
        end
    end

    // Register read port, data valid only the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rd_data_reg <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `PBR_OFS_RECOVERY: rd_data_reg <= {1'b0, clk_sel_reg,
                    chas_en_reg, prev_reg, mode2_reg, pok_en_reg, policy_reg};
                `PBR_OFS_HISTORY: rd_data_reg <= hist_reg;
                `PBR_OFS_SELECT: rd_data_reg <= {5'h00, sel_reg};
                `PBR_OFS_WAKE_STS: rd_data_reg <= {5'h00, wake_sts_reg};
                `PBR_OFS_WAKE_EN: rd_data_reg <= {5'h00, wake_en_reg};
                default: rd_data_reg <= 8'h00;
            endcase
        end else begin
            rd_data_reg <= 8'h00;
        end
    end

    assign button_request_out_n = button_reg;
    assign supply_on_out_n = supply_reg;
    assign system_good_out = good_reg;
    assign wake_request_out_n = wake_reg;
    assign rd_data = rd_data_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    chk_supply_inverse: assert property ( // [RULE_01]
        $changed(pin_reg[P_SLEEP]) |=> supply_on_out_n == !$past(pin_reg[P_SLEEP])
    ) else $error("supply-on does not follow sleep input");

    chk_chassis_hold: assert property ( // [RULE_02]
        (chas_en_reg && !pin_reg[P_CHAS]) |=> !button_request_out_n
    ) else $error("chassis button not forwarded");

    chk_keyboard_hold: assert property ( // [RULE_03]
        !keyboard_button_status_n |=> !button_request_out_n
    ) else $error("keyboard button not forwarded");

    chk_pulse_length: assert property ( // [RULE_04]
        ($past(rec_reg) == REC_PULSE && rec_reg == REC_DONE) |->
            $past(pulse_cnt_reg) == 24'(PULSE_CYC - 1)
    ) else $error("recovery pulse has wrong length");

    chk_policy_off: assert property ( // [RULE_06]
        (rec_reg == REC_DECIDE && policy_reg != 2'h1 && policy_reg != 2'h2)
            |=> ##1 rec_reg == REC_DONE
    ) else $error("recovery pulse with supply-off policy");

    chk_history_copy: assert property ( // [RULE_10]
        (rec_reg == REC_DECIDE && battery_rst_n) |=>
            hist_reg == $past(shift_reg) ##1 shift_reg == 8'h00
    ) else $error("history not copied before clear");

    chk_power_ok: assert property ( // [RULE_15]
        system_good_out |-> $past(deb_reg) && $past(pin_reg[P_SGOOD])
    ) else $error("power-ok high with a low input");

    chk_debounce_time: assert property ( // [RULE_14]
        $changed(deb_reg) |-> $past(deb_cnt_reg) == 10'(DEB_TICKS - 1) &&
            $past(ext_tick)
    ) else $error("debounced output changed early");

    chk_wake_output: assert property ( // [RULE_17]
        (|(wake_sts_reg & wake_en_reg)) |=> !wake_request_out_n
    ) else $error("enabled wake status not on pin");

endmodule : pbr_power_ctl

// File: src/pbr_map.svh
// Offsets, field positions, reset values and timing counts of the block.
// Assumes a 25 MHz core clock and a 32.768 kHz slow clock on a pin.
// Behaviour
// [RULE_01] Supply-on output is inverse of sleep input
// [RULE_02] Enabled chassis button low holds button low
// [RULE_03] Keyboard button status low holds button low
// [RULE_04] Recovery on: button pulse 0.5 s, under 4 s
// [RULE_05] Policy 00/11 off, 01 on, 10 previous
// [RULE_06] Policy off leaves button output untouched
// [RULE_07] Mode 1 latches supply level on first failure
// [RULE_08] Mode 2 samples supply every 0.5 s
// [RULE_09] Mode 2 previous state from selected history bit
// [RULE_10] Copy history before clearing shift register
// [RULE_11] Saved history reset only by battery reset
// [RULE_12] Mode 2 latches level when standby drops
// [RULE_13] Software picks history span covering power-down
// [RULE_14] Debounce front-panel reset 16 ms both edges
// [RULE_15] Power-ok high only when both inputs high
// [RULE_16] Selectable internal slow clock, debounce uses external
// [RULE_17] Wake events set status, enabled ones assert pin
// [RULE_18] Wake enables default one, battery powered
// [RULE_19] Wake sources: chassis, keyboard, power return
// [RULE_20] South bridge after-loss bit must be one
// [RULE_21] South bridge turns button into sleep input
// [RULE_22] Recovery registers kept on battery rail
// [RULE_23] Debounce counter restarts on input change
`ifndef PBR_MAP_SVH
`define PBR_MAP_SVH

`define PBR_OFS_RECOVERY 8'h49
`define PBR_OFS_HISTORY 8'h4A
`define PBR_OFS_SELECT 8'h53
`define PBR_OFS_WAKE_STS 8'h54
`define PBR_OFS_WAKE_EN 8'h55

`define PBR_BIT_POLICY_LO 0
`define PBR_BIT_POK_EN 2
`define PBR_BIT_MODE2 3
`define PBR_BIT_PREV 4
`define PBR_BIT_CHAS_EN 5
`define PBR_BIT_CLK_SEL 6

`define PBR_WAKE_CHASSIS 0
`define PBR_WAKE_KEYBOARD 1
`define PBR_WAKE_RETURN 2

`define PBR_RST_POLICY 2'h0
`define PBR_RST_WAKE_EN 3'h7
`define PBR_RST_CHAS_EN 1'h1

`define PBR_CLK_HZ 25000000
`define PBR_SLOW_HZ 32768
`define PBR_T_PULSE_MS 500
`define PBR_T_SAMPLE_MS 500
`define PBR_T_DEB_US 16000

`define PBR_PULSE_CYC ((`PBR_CLK_HZ / 1000) * `PBR_T_PULSE_MS)
`define PBR_SAMPLE_TICKS ((`PBR_SLOW_HZ * `PBR_T_SAMPLE_MS) / 1000)
`define PBR_DEB_TICKS ((`PBR_T_DEB_US * `PBR_SLOW_HZ + 999999) / 1000000)
`define PBR_DIV_CYC ((`PBR_CLK_HZ + `PBR_SLOW_HZ / 2) / `PBR_SLOW_HZ)

`endif

// File: src/pbr_pkg.sv
// Types shared by the power button and recovery block.
// Assumes nothing beyond the register map header.
package pbr_pkg;
    typedef logic [7:0] pbr_byte_t;
    typedef enum logic [2:0] {
        REC_DECIDE,
        REC_COPY,
        REC_PULSE,
        REC_DONE
    } pbr_rec_t;
endpackage : pbr_pkg

// File: bench/pbr_sb_model.sv
// South bridge and supply model facing the power button block.
// Assumes the block's core clock; the bridge keeps its state across
// block resets, as a real bridge on its own rail would.
module pbr_sb_model #(
    parameter int DLY = 3
) (
    input wire logic mclk,
    input wire logic button_request_out_n,
    input wire logic supply_on_out_n,
    input wire logic pg_drop,
    output logic sleep_state_in_n,
    output logic supply_good_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // After-loss bit set: the bridge comes up off and waits
    logic on_reg = 1'b0;
    logic [7:0] low_cnt = 8'h00;
    logic [15:0] pipe = 16'h0000;
    logic [3:0] good_dly = 4'h0;
    // Presses under four cycles count as noise, longer ones toggle
    always @(posedge mclk) begin
        if (button_request_out_n == 1'b0) begin
            if (low_cnt != 8'hFF) begin
                low_cnt <= low_cnt + 8'h01;
            end
        end else begin
            if (low_cnt >= 8'h04) begin
                on_reg <= ~on_reg;
            end
            low_cnt <= 8'h00;
        end
    end
    // Sleep line follows the decision DLY cycles late
    always @(posedge mclk) begin
        pipe <= {pipe[14:0], on_reg};
        good_dly <= {good_dly[2:0], ~supply_on_out_n};
    end
    assign sleep_state_in_n = pipe[DLY-1];
    // The supply only reports good some cycles after being switched on
    assign supply_good_in = good_dly[3] & ~pg_drop;
endmodule : pbr_sb_model

// File: bench/tb.sv
// Self-checking bench for the power button and recovery block.
// Assumes shortened counts and a slow tick every ten core cycles.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pbr_pkg::*;
    localparam int PULSE = 20;
    localparam int LIMIT = 20000;
    logic mclk, nrst, battery_rst_n, chassis_button_in_n, pg_drop;
    logic keyboard_button_status_n, front_panel_reset_in_n, slow_clk_in;
    logic main_rail_good_in, standby_rail_good_in, standby_above_min_in;
    logic wr_en, rd_en, sleep_state_in_n, supply_good_in;
    logic button_request_out_n, supply_on_out_n, system_good_out;
    logic wake_request_out_n;
    pbr_byte_t addr, wr_data, rd_data, rdv;
    logic [2:0] slow_cnt;
    logic [1:0] pol [3] = '{2'h0, 2'h1, 2'h3};
    int n_fail, samples_checked, cycles;

    pbr_power_ctl #(.PULSE_CYC(PULSE), .SAMPLE_TICKS(4), .DEB_TICKS(3),
        .DIV_CYC(4)) pbr_power_ctl_inst (.mclk(mclk), .nrst(nrst),
        .battery_rst_n(battery_rst_n), .sleep_state_in_n(sleep_state_in_n),
        .chassis_button_in_n(chassis_button_in_n),
        .keyboard_button_status_n(keyboard_button_status_n),
        .supply_good_in(supply_good_in),
        .front_panel_reset_in_n(front_panel_reset_in_n),
        .slow_clk_in(slow_clk_in), .main_rail_good_in(main_rail_good_in),
        .standby_rail_good_in(standby_rail_good_in),
        .power_ok_input(1'b1), .standby_above_min_in(standby_above_min_in),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .button_request_out_n(button_request_out_n),
        .supply_on_out_n(supply_on_out_n), .system_good_out(system_good_out),
        .wake_request_out_n(wake_request_out_n), .rd_data(rd_data));

    pbr_sb_model #(.DLY(3)) pbr_sb_model_inst (.mclk(mclk),
        .button_request_out_n(button_request_out_n),
        .supply_on_out_n(supply_on_out_n), .pg_drop(pg_drop),
        .sleep_state_in_n(sleep_state_in_n),
        .supply_good_in(supply_good_in));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Slow clock made from the core clock keeps the edges race free
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (slow_cnt == 3'h4) begin
            slow_cnt <= 3'h0;
            slow_clk_in <= ~slow_clk_in;
        end else begin
            slow_cnt <= slow_cnt + 3'h1;
        end
        if (cycles == LIMIT) begin
            n_fail++;
            test_done();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        rdv = rd_data;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        check(rdv, exp);
    endtask : rd_chk

    task automatic set_supply(input logic v);
        if (supply_on_out_n === v) begin
            chassis_button_in_n <= 1'b0;
            wait_cyc(10);
            chassis_button_in_n <= 1'b1;
            wait_cyc(40);
        end
    endtask : set_supply

    // Standby loss and return, then count cycles of button low
    task automatic recover(input int exp);
        int cnt;
        cnt = 0;
        @(posedge mclk);
        nrst <= 1'b0;
        wait_cyc(20);
        nrst <= 1'b1;
        repeat (60) begin
            @(negedge mclk);
            if (button_request_out_n === 1'b0) cnt++;
        end
        check(cnt[7:0], exp[7:0]);
    endtask : recover

    task automatic fill;
        set_supply(1'b1);
        wait_cyc(400);
        set_supply(1'b0);
        wait_cyc(150);
    endtask : fill

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        nrst = 1'b0;
        battery_rst_n = 1'b0;
        chassis_button_in_n = 1'b1;
        keyboard_button_status_n = 1'b1;
        front_panel_reset_in_n = 1'b1;
        slow_clk_in = 1'b0;
        slow_cnt = 3'h0;
        main_rail_good_in = 1'b1;
        standby_rail_good_in = 1'b1;
        standby_above_min_in = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        pg_drop = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        wait_cyc(20);
        nrst <= 1'b1;
        battery_rst_n <= 1'b1;
        wait_cyc(5);
        rd_chk(8'h49, 8'h20);
        rd_chk(8'h53, 8'h00);
        rd_chk(8'h55, 8'h07);
        wr(8'h4A, 8'hFF);
        rd_chk(8'h4A, 8'h00);
        wr(8'h60, 8'hFF);
        rd_chk(8'h60, 8'h00);
        $display("test registers done");
        set_supply(1'b1);
        check(supply_on_out_n, !sleep_state_in_n);
        chassis_button_in_n <= 1'b0;
        wait_cyc(8);
        check(button_request_out_n, 1'b0);
        check(wake_request_out_n, 1'b0);
        chassis_button_in_n <= 1'b1;
        wait_cyc(8);
        check(button_request_out_n, 1'b1);
        rd_chk(8'h54, 8'h01);
        wr(8'h54, 8'h01);
        rd_chk(8'h54, 8'h00);
        check(wake_request_out_n, 1'b1);
        wait_cyc(20);
        check(supply_on_out_n, !sleep_state_in_n);
        wr(8'h49, 8'h00);
        chassis_button_in_n <= 1'b0;
        wait_cyc(8);
        check(button_request_out_n, 1'b1);
        chassis_button_in_n <= 1'b1;
        rd_chk(8'h54, 8'h01);
        wr(8'h54, 8'h07);
        wr(8'h49, 8'h20);
        wr(8'h55, 8'h00);
        keyboard_button_status_n <= 1'b0;
        wait_cyc(8);
        check(button_request_out_n, 1'b0);
        check(wake_request_out_n, 1'b1);
        keyboard_button_status_n <= 1'b1;
        wait_cyc(8);
        rd_chk(8'h54, 8'h02);
        wr(8'h55, 8'h02);
        wait_cyc(3);
        check(wake_request_out_n, 1'b0);
        wr(8'h54, 8'h02);
        wait_cyc(3);
        check(wake_request_out_n, 1'b1);
        wr(8'h55, 8'h07);
        $display("test buttons done");
        set_supply(1'b1);
        wait_cyc(60);
        check(system_good_out, 1'b1);
        pg_drop <= 1'b1;
        wait_cyc(10);
        check(system_good_out, 1'b0);
        pg_drop <= 1'b0;
        wait_cyc(10);
        front_panel_reset_in_n <= 1'b0;
        wait_cyc(12);
        front_panel_reset_in_n <= 1'b1;
        wait_cyc(60);
        check(system_good_out, 1'b1);
        front_panel_reset_in_n <= 1'b0;
        wait_cyc(60);
        check(system_good_out, 1'b0);
        front_panel_reset_in_n <= 1'b1;
        wait_cyc(15);
        check(system_good_out, 1'b0);
        wait_cyc(45);
        check(system_good_out, 1'b1);
        $display("test front panel done");
        wr(8'h49, 8'h22);
        main_rail_good_in <= 1'b0;
        wait_cyc(10);
        set_supply(1'b0);
        standby_rail_good_in <= 1'b0;
        wait_cyc(10);
        rd_chk(8'h49, 8'h32);
        main_rail_good_in <= 1'b1;
        standby_rail_good_in <= 1'b1;
        recover(PULSE);
        foreach (pol[i]) begin
            wr(8'h49, {6'h08, pol[i]});
            recover(pol[i] == 2'h1 ? PULSE : 0);
            rd_chk(8'h54, pol[i] == 2'h1 ? 8'h04 : 8'h00);
            rd(8'h49);
            check(rdv & 8'hEF, {6'h08, pol[i]});
        end
        $display("test mode 1 done");
        wr(8'h49, 8'h2A);
        wr(8'h53, 8'h07);
        fill();
        recover(PULSE);
        rd(8'h4A);
        check(rdv & 8'h81, 8'h80);
        set_supply(1'b0);
        standby_above_min_in <= 1'b0;
        wait_cyc(10);
        rd(8'h49);
        check(rdv & 8'h10, 8'h00);
        standby_above_min_in <= 1'b1;
        fill();
        wr(8'h53, 8'h00);
        recover(0);
        $display("test mode 2 done");
        test_done();
    end
endmodule : tb
